// ### core/tsc_consts.svh
// constants for the two-speed start-up and clock-fail block
// assumes one 200 MHz clock and 8-bit registers on a plain port
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_ADDR_CTRL     2'h0
`define TSC_ADDR_STAT     2'h1
`define TSC_ADDR_FLAG     2'h2
`define TSC_ADDR_IRQEN    2'h3
`define TSC_CTRL_RESET    8'h38
`define TSC_BIT_SPLL      7
`define TSC_BIT_EXTERNAL_CLOCK_ACTIVE      5
`define TSC_BIT_T1RDY     7
`define TSC_BIT_FLAG      7
`define TSC_BIT_IRQEN     7
`define TSC_OST_COUNT     11'h400
`define TSC_LF_DIV        7'h40
`define TSC_MODE_EC       3'h3
`define TSC_MODE_INTERNAL_OSC_BLOCK   3'h4
`endif

// ### core/tsc_pkg.sv
// types for the two-speed start-up and clock-fail block
// assumes tsc_consts.svh for the numbers
package tsc_pkg;
  typedef enum logic [2:0] {
    TSC_POR   = 3'h0,
    TSC_OST   = 3'h1,
    TSC_WINT  = 3'h2,
    TSC_HOLD  = 3'h3,
    TSC_EXT   = 3'h4,
    TSC_FAIL  = 3'h5,
    TSC_SLEEP = 3'h6,
    TSC_INT   = 3'h7
  } tsc_state_t;
  typedef enum logic [1:0] {
    TSC_SRC_INT = 2'h0,
    TSC_SRC_EXT = 2'h1,
    TSC_SRC_T1  = 2'h2
  } tsc_src_t;
  typedef enum logic [1:0] {
    TSC_OSC_LF = 2'h0,
    TSC_OSC_MF = 2'h1,
    TSC_OSC_HF = 2'h2
  } tsc_osc_t;
endpackage

// ### core/tsc_clock_ctrl.sv
// clock source control: two-speed start-up and clock-fail monitor
// assumes fuses, sleep and wake are static or from the mclk domain;
// oscillator pins and analog status are asynchronous
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_clock_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        two_speed_enable_fuse,
  input  wire logic        fail_monitor_enable_fuse,
  input  wire logic        pll_enable_fuse,
  input  wire logic [2:0]  oscillator_mode_fuse,
  input  wire logic        powerup_timer_done,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic        timer1_osc_enable,
  input  wire logic        ext_clk,
  input  wire logic        t1_clk,
  input  wire logic        lf_osc_clk,
  input  wire logic        int_osc_clk,
  input  wire logic [6:0]  osc_flags,
  output tsc_pkg::tsc_src_t sys_clk_src,
  output logic             sys_clk_hold,
  output logic             cpu_run,
  output tsc_pkg::tsc_osc_t int_osc_src,
  output logic      [3:0]  int_freq,
  output logic             pll_on,
  output logic             clock_fail_irq
);
  // osc_flags: 6 t1 ready, 5 pll ready, 4 hf ready, 3 hf 2%,
  // 2 mf ready, 1 lf ready, 0 hf 0.5%

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode < `TSC_MODE_EC);
  endfunction

  // where a fresh start leads, per clock select and mode
  function automatic tsc_pkg::tsc_state_t start_of(
      input logic [1:0] scs, input logic [2:0] mode);
    if (scs[1])
      start_of = tsc_pkg::TSC_INT;
    else if (scs == 2'h1 || is_crystal(mode))
      start_of = tsc_pkg::TSC_OST;
    else if (mode == `TSC_MODE_INTERNAL_OSC_BLOCK)
      start_of = tsc_pkg::TSC_INT;
    else
      start_of = tsc_pkg::TSC_EXT;
  endfunction

  function automatic tsc_pkg::tsc_osc_t osc_of(input logic [3:0] f);
    if (f[3:1] == 3'h0)
      osc_of = tsc_pkg::TSC_OSC_LF;
    else if (f[3] || f == 4'h3)
      osc_of = tsc_pkg::TSC_OSC_HF;
    else
      osc_of = tsc_pkg::TSC_OSC_MF;
  endfunction

  // ----------------------------------------------------------------
  // registers and synchronisers
  // ----------------------------------------------------------------
  tsc_pkg::tsc_state_t state;
  tsc_pkg::tsc_state_t next_state;
  logic [7:0]  ctrl;
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [3:0]  clk_prev;
  logic [10:0] ost_cnt;
  logic [5:0]  div_cnt;
  logic        latch;
  logic        external_clock_active;
  logic        fail_flag;
  logic        irq_en;
  logic        mon_now;
  logic        mon_fall;
  logic        int_fall;
  logic        lf_rise;
  logic        samp_rise;
  logic        samp_fall;
  logic        mon_active;
  logic        fail_det;
  logic        two_speed;
  logic        scs_change;
  logic        ctrl_wr;
  logic [7:0]  status;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
    end else begin
      sync1 <= {osc_flags, int_osc_clk, lf_osc_clk, t1_clk, ext_clk};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      clk_prev <= 4'h0;
    else
      clk_prev <= sync2[3:0];
  end

  // monitored clock follows the select (timer1 or fuse source)
  assign mon_now  = (ctrl[1:0] == 2'h1) ? sync2[1] : sync2[0];
  assign mon_fall = ((ctrl[1:0] == 2'h1) ? clk_prev[1] : clk_prev[0])
                    && !mon_now;
  assign lf_rise  = sync2[2] && !clk_prev[2];
  assign int_fall = clk_prev[3] && !sync2[3];

  assign ctrl_wr    = reg_wr && reg_addr == `TSC_ADDR_CTRL;
  assign scs_change = ctrl_wr && reg_wdata[1:0] != ctrl[1:0];
  assign two_speed = fail_monitor_enable_fuse ||
                     (two_speed_enable_fuse && ctrl[1:0] == 2'h0 &&
                      is_crystal(oscillator_mode_fuse));

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      ctrl <= `TSC_CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
  end

  // ----------------------------------------------------------------
  // start-up sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (sleep_req) begin
      next_state = tsc_pkg::TSC_SLEEP;
    end else if (scs_change && state != tsc_pkg::TSC_SLEEP &&
                 state != tsc_pkg::TSC_POR) begin
      next_state = start_of(reg_wdata[1:0], oscillator_mode_fuse);
    end else begin
      unique case (state)
        tsc_pkg::TSC_POR:
          if (powerup_timer_done)
            next_state = start_of(ctrl[1:0], oscillator_mode_fuse);
        tsc_pkg::TSC_OST:
          if (mon_fall && ost_cnt == `TSC_OST_COUNT - 11'h1)
            next_state = tsc_pkg::TSC_WINT;
        tsc_pkg::TSC_WINT:
          if (int_fall)
            next_state = tsc_pkg::TSC_HOLD;
        tsc_pkg::TSC_HOLD:
          if (mon_fall)
            next_state = tsc_pkg::TSC_EXT;
        tsc_pkg::TSC_EXT:
          if (fail_det)
            next_state = tsc_pkg::TSC_FAIL;
        tsc_pkg::TSC_FAIL:
          next_state = tsc_pkg::TSC_FAIL;
        tsc_pkg::TSC_SLEEP:
          if (wake_req)
            next_state = start_of(ctrl[1:0], oscillator_mode_fuse);
        tsc_pkg::TSC_INT:
          next_state = tsc_pkg::TSC_INT;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      state <= tsc_pkg::TSC_POR;
    else
      state <= next_state;
  end

  // counts 1024 falls of the monitored source (external or timer1, per the select)
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      ost_cnt <= 11'h000;
    else if (next_state != tsc_pkg::TSC_OST || state != tsc_pkg::TSC_OST)
      ost_cnt <= 11'h000;
    else if (mon_fall)
      ost_cnt <= ost_cnt + 11'h001;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      external_clock_active         <= 1'b0;
      sys_clk_hold <= 1'b0;
      sys_clk_src  <= tsc_pkg::TSC_SRC_INT;
      cpu_run      <= 1'b0;
    end else begin
      external_clock_active <= (next_state == tsc_pkg::TSC_HOLD ||
               next_state == tsc_pkg::TSC_EXT) && !ctrl[1];
      sys_clk_hold <= next_state == tsc_pkg::TSC_HOLD;
      if (next_state == tsc_pkg::TSC_EXT)
        sys_clk_src <= (ctrl[1:0] == 2'h1) ? tsc_pkg::TSC_SRC_T1
                                           : tsc_pkg::TSC_SRC_EXT;
      else
        sys_clk_src <= tsc_pkg::TSC_SRC_INT;
      unique case (next_state)
        tsc_pkg::TSC_POR, tsc_pkg::TSC_SLEEP:
          cpu_run <= 1'b0;
        tsc_pkg::TSC_OST, tsc_pkg::TSC_WINT, tsc_pkg::TSC_HOLD:
          cpu_run <= two_speed;
        tsc_pkg::TSC_EXT, tsc_pkg::TSC_FAIL, tsc_pkg::TSC_INT:
          cpu_run <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fail detector
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      div_cnt <= 6'h00;
    else if (lf_rise)
      div_cnt <= div_cnt + 6'h01;
  end

  assign samp_rise = lf_rise && div_cnt == 6'h1f;
  assign samp_fall = lf_rise && div_cnt == 6'h3f;

  // fall of the source wins over a sample rise in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      latch <= 1'b0;
    else if (mon_fall)
      latch <= 1'b1;
    else if (samp_rise)
      latch <= 1'b0;
  end

  assign mon_active = fail_monitor_enable_fuse &&
                      state == tsc_pkg::TSC_EXT && !ctrl[1];
  assign fail_det   = mon_active && samp_fall && !latch;

  // ----------------------------------------------------------------
  // fail flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      fail_flag <= 1'b0;
    else if (fail_det)
      fail_flag <= 1'b1;
    else if (reg_wr && reg_addr == `TSC_ADDR_FLAG &&
             !reg_wdata[`TSC_BIT_FLAG] && state != tsc_pkg::TSC_FAIL)
      fail_flag <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      irq_en <= 1'b0;
    else if (reg_wr && reg_addr == `TSC_ADDR_IRQEN)
      irq_en <= reg_wdata[`TSC_BIT_IRQEN];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clock_fail_irq <= 1'b0;
      pll_on         <= 1'b0;
      int_osc_src    <= tsc_pkg::TSC_OSC_MF;
      int_freq       <= 4'h7;
    end else begin
      clock_fail_irq <= fail_flag && irq_en;
      pll_on <= pll_enable_fuse || ctrl[`TSC_BIT_SPLL];
      int_osc_src <= osc_of(ctrl[6:3]);
      int_freq    <= ctrl[6:3];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  assign status = {timer1_osc_enable ? sync2[10] : 1'b1, sync2[9],
                   external_clock_active, sync2[8], sync2[7], sync2[6], sync2[5],
                   sync2[4]};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TSC_ADDR_CTRL:  reg_rdata <= ctrl;
        `TSC_ADDR_STAT:  reg_rdata <= status;
        `TSC_ADDR_FLAG:  reg_rdata <= {fail_flag, 7'h00};
        `TSC_ADDR_IRQEN: reg_rdata <= {irq_en, 7'h00};
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_gate;
    @(posedge mclk) disable iff (!rst_b)
    (next_state == tsc_pkg::TSC_OST && !two_speed) |=> !cpu_run;
  endproperty
  a_gate: assert property (p_gate)
    else $error("start-up ran code without two-speed");

  property p_por;
    @(posedge mclk) disable iff (!rst_b)
    (state == tsc_pkg::TSC_POR && !powerup_timer_done && !sleep_req)
      |=> state == tsc_pkg::TSC_POR;
  endproperty
  a_por: assert property (p_por)
    else $error("left reset wait early");

  property p_ost_int;
    @(posedge mclk) disable iff (!rst_b)
    state == tsc_pkg::TSC_OST |-> sys_clk_src == tsc_pkg::TSC_SRC_INT;
  endproperty
  a_ost_int: assert property (p_ost_int)
    else $error("external clock used during timer count");

  property p_hold;
    @(posedge mclk) disable iff (!rst_b)
    (state == tsc_pkg::TSC_WINT && int_fall && !sleep_req && !scs_change)
      |=> sys_clk_hold && external_clock_active ##1 1'b1;
  endproperty
  a_hold: assert property (p_hold)
    else $error("no hold after internal fall");

  property p_fail;
    @(posedge mclk) disable iff (!rst_b)
    fail_det |=> fail_flag && sys_clk_src == tsc_pkg::TSC_SRC_INT;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure not handled");

  property p_keep;
    @(posedge mclk) disable iff (!rst_b)
    (state == tsc_pkg::TSC_FAIL && fail_flag) |=> fail_flag;
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag cleared during fail state");

  property p_sleep;
    @(posedge mclk) disable iff (!rst_b)
    sleep_req |=> state == tsc_pkg::TSC_SLEEP && !external_clock_active && !cpu_run;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not abort start-up");

  property p_pll;
    @(posedge mclk) disable iff (!rst_b)
    pll_enable_fuse |=> pll_on;
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll off under fuse");

  property p_irq;
    @(posedge mclk) disable iff (!rst_b)
    $rose(fail_flag && irq_en) |-> !clock_fail_irq ##1 clock_fail_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");
endmodule
`default_nettype wire

// ### bench/tsc_xtal_model.sv
// behavioural crystal or external clock source feeding one clock pin
// assumes the bench owns run; a stalled source holds its last level
`timescale 1ns/1ps
`default_nettype none
module tsc_xtal_model #(
  parameter int HALF_NS = 20
) (
  input  wire logic run,
  output var logic  clk
);
  // --------------------------------------------------------------
  // oscillation
  // --------------------------------------------------------------
  // stalling on command models a dead crystal
  initial begin
    clk = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) begin
        clk = ~clk;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tsc_clock_ctrl_tb.sv
// bench top: register tasks, start-up, fail and sleep sequences
// assumes tsc_clock_ctrl and tsc_xtal_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_clock_ctrl_tb;
  logic mclk     = 1'b0;
  logic lf       = 1'b0;
  logic ic       = 1'b0;
  logic saw_hold = 1'b0;
  logic rst_b, reg_wr, reg_rd, ts_f, fm_f, pll_f, powerup_timer, slp, wake;
  logic t1en, ext_run, ext_clk, t1_clk, hold, run, pll_on, irq;
  logic [1:0]        reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, d;
  logic [2:0]        mode;
  logic [6:0]        flags;
  logic [3:0]        freq;
  tsc_pkg::tsc_src_t src;
  tsc_pkg::tsc_osc_t osc;
  int                n_mismatch, checks, n;
  logic [3:0]        fv [6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'he, 4'hf};
  logic [1:0]        ov [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  tsc_xtal_model #(.HALF_NS(20)) ext_u (.run(ext_run), .clk(ext_clk));
  tsc_xtal_model #(.HALF_NS(25)) t1_u (.run(1'b1), .clk(t1_clk));
  tsc_clock_ctrl dut_u (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .two_speed_enable_fuse(ts_f),
    .fail_monitor_enable_fuse(fm_f), .pll_enable_fuse(pll_f),
    .oscillator_mode_fuse(mode), .powerup_timer_done(powerup_timer),
    .sleep_req(slp), .wake_req(wake), .timer1_osc_enable(t1en),
    .ext_clk(ext_clk), .t1_clk(t1_clk), .lf_osc_clk(lf),
    .int_osc_clk(ic), .osc_flags(flags), .sys_clk_src(src),
    .sys_clk_hold(hold), .cpu_run(run), .int_osc_src(osc),
    .int_freq(freq), .pll_on(pll_on), .clock_fail_irq(irq)
  );
  // --------------------------------------------------------------
  // clocks and helpers
  // --------------------------------------------------------------
  always #2.5 mclk = ~mclk;
  always #10 lf = ~lf;
  always #15 ic = ~ic;
  always @(posedge mclk) if (hold === 1'b1) saw_hold <= 1'b1;
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task wait_src(input tsc_pkg::tsc_src_t s, input int lim);
    n = 0;
    #1;
    while (src !== s && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("sys_clk_src", {6'h0, s}, {6'h0, src});
  endtask
  task pulse_sleep(input logic w);
    @(posedge mclk);
    if (w) wake <= 1'b1;
    else slp <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    slp  <= 1'b0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    summarize;
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, slp, wake, t1en} = '0;
    {ts_f, fm_f, ext_run} = 3'b111;
    {pll_f, powerup_timer} = '0;
    {reg_addr, reg_wdata, mode, flags} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`TSC_ADDR_CTRL, d);
    chk("ctrl_reset", `TSC_CTRL_RESET, d);
    chk("int_freq", 8'h07, {4'h0, freq});
    @(posedge mclk);
    flags <= 7'h09;
    cyc(4);
    rd(`TSC_ADDR_STAT, d);
    chk("status", 8'h89, d);
    @(posedge mclk);
    t1en <= 1'b1;
    cyc(4);
    rd(`TSC_ADDR_STAT, d);
    chk("status_t1", 8'h09, d);
    for (int i = 0; i < 6; i++) begin
      wr(`TSC_ADDR_CTRL, {1'b1, fv[i], 3'b100});
      rd(`TSC_ADDR_CTRL, d);
      chk("ctrl_rb", {1'b1, fv[i], 3'b000}, d);
      chk("int_osc_src", {6'h0, ov[i]}, {6'h0, osc});
      chk("pll_on", 8'h01, {7'h0, pll_on});
    end
    wr(`TSC_ADDR_CTRL, 8'h38);
    cyc(2);
    chk("pll_off", 8'h00, {7'h0, pll_on});
    $display("test registers done");
    @(posedge mclk);
    powerup_timer <= 1'b1;
    cyc(200);
    chk("src_startup", 8'h00, {6'h0, src});
    chk("cpu_run", 8'h01, {7'h0, run});
    rd(`TSC_ADDR_STAT, d);
    chk("active_early", 8'h00, {7'h0, d[`TSC_BIT_EXTERNAL_CLOCK_ACTIVE]});
    wait_src(tsc_pkg::TSC_SRC_EXT, 12000);
    chk("ost_span", 8'h01, {7'h0, n > 7500});
    chk("held_low", 8'h01, {7'h0, saw_hold});
    rd(`TSC_ADDR_STAT, d);
    chk("active", 8'h01, {7'h0, d[`TSC_BIT_EXTERNAL_CLOCK_ACTIVE]});
    $display("test two_speed done");
    wr(`TSC_ADDR_IRQEN, 8'h80);
    cyc(3);
    chk("irq_idle", 8'h00, {7'h0, irq});
    ext_run <= 1'b0;
    wait_src(tsc_pkg::TSC_SRC_INT, 1000);
    rd(`TSC_ADDR_FLAG, d);
    chk("fail_flag", 8'h01, {7'h0, d[`TSC_BIT_FLAG]});
    cyc(2);
    chk("irq", 8'h01, {7'h0, irq});
    wr(`TSC_ADDR_FLAG, 8'h00);
    rd(`TSC_ADDR_FLAG, d);
    chk("flag_kept", 8'h01, {7'h0, d[`TSC_BIT_FLAG]});
    wr(`TSC_ADDR_CTRL, 8'h3a);
    wr(`TSC_ADDR_FLAG, 8'h00);
    rd(`TSC_ADDR_FLAG, d);
    chk("flag_clr", 8'h00, {7'h0, d[`TSC_BIT_FLAG]});
    cyc(2);
    chk("irq_clr", 8'h00, {7'h0, irq});
    $display("test fail_safe done");
    ext_run <= 1'b1;
    wr(`TSC_ADDR_CTRL, 8'h38);
    cyc(300);
    chk("src_restart", 8'h00, {6'h0, src});
    pulse_sleep(1'b0);
    cyc(9000);
    rd(`TSC_ADDR_STAT, d);
    chk("active_abort", 8'h00, {7'h0, d[`TSC_BIT_EXTERNAL_CLOCK_ACTIVE]});
    chk("cpu_sleep", 8'h00, {7'h0, run});
    pulse_sleep(1'b1);
    wait_src(tsc_pkg::TSC_SRC_EXT, 12000);
    $display("test sleep done");
    wr(`TSC_ADDR_CTRL, 8'h39);
    wait_src(tsc_pkg::TSC_SRC_T1, 12000);
    chk("t1_ost_span", 8'h01, {7'h0, n > 9000});
    $display("test timer1 done");
    @(posedge mclk);
    rst_b <= 1'b0;
    {ts_f, fm_f} <= 2'b00;
    cyc(5);
    @(posedge mclk);
    rst_b <= 1'b1;
    cyc(20);
    chk("run_no_two_speed", 8'h00, {7'h0, run});
    chk("src_no_two_speed", 8'h00, {6'h0, src});
    $display("test no_two_speed done");
    @(posedge mclk);
    rst_b <= 1'b0;
    {ts_f, fm_f} <= 2'b11;
    mode  <= `TSC_MODE_EC;
    pll_f <= 1'b1;
    cyc(5);
    @(posedge mclk);
    rst_b <= 1'b1;
    wait_src(tsc_pkg::TSC_SRC_EXT, 50);
    chk("pll_fuse", 8'h01, {7'h0, pll_on});
    ext_run <= 1'b0;
    wait_src(tsc_pkg::TSC_SRC_INT, 1000);
    rd(`TSC_ADDR_FLAG, d);
    chk("fail_flag_ec", 8'h01, {7'h0, d[`TSC_BIT_FLAG]});
    $display("test ext_input done");
    summarize;
  end
endmodule
`default_nettype wire
